// *** design/frrc_regs.vh ***
// Purpose: command codes, field layout, reset values and timing of the
//          fault response and restart controller
// Assumes: 125 MHz core clock
// Notes:   definitions only
`ifndef FRRC_REGS_VH
`define FRRC_REGS_VH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define FRRC_CMD_FLAGS        8'hD8
`define FRRC_CMD_ACTION       8'hD9
`define FRRC_CMD_INTERVAL     8'hDA

// ---------------------------------------------------------------
// action config fields
// ---------------------------------------------------------------
`define FRRC_STORE_PEAK_BIT   15
`define FRRC_OV_LSB           0
`define FRRC_UV_LSB           2
`define FRRC_OC_LSB           4
`define FRRC_OT_LSB           6
`define FRRC_NC_LSB           8
`define FRRC_ACTION_MASK      16'h83FF
`define FRRC_NUM_FAULTS       5

// ---------------------------------------------------------------
// action codes
// ---------------------------------------------------------------
`define FRRC_ACT_FLAG         2'h0
`define FRRC_ACT_LATCH        2'h1
`define FRRC_ACT_RETRY        2'h2
`define FRRC_ACT_FLAG_STORE   2'h3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FRRC_ACTION_RST       16'h0000
`define FRRC_INTERVAL_RST     16'h0000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FRRC_CLK_PERIOD_NS    8
`define FRRC_RETRY_UNIT_NS    100000
`define FRRC_RETRY_UNIT_CYC   (`FRRC_RETRY_UNIT_NS / `FRRC_CLK_PERIOD_NS)
`define FRRC_DAC_STEP_CYC     16

`endif

// *** design/frrc_ramp.v ***
// Purpose: reference dac ramp toward target while run, down while stopped
// Assumes: one lsb per step pulse
// Notes:   never steps straight to zero
`timescale 1ns/1ps

module frrc_ramp (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        run,
  input  wire [11:0] target,
  input  wire        step,
  output reg  [11:0] dac_q
);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      dac_q <= 12'h000;
    else if (step)
    begin
      if (run && dac_q < target)
        dac_q <= dac_q + 12'h001;
      else if (run && dac_q > target)
        dac_q <= dac_q - 12'h001;
      else if (!run && dac_q != 12'h000)
        dac_q <= dac_q - 12'h001; // R8
    end
  end

endmodule // frrc_ramp

// *** design/frrc_ctrl.v ***
// Purpose: fault response, shutdown and periodic restart of a load supply
// Assumes: fault detect inputs are one-cycle pulses from the monitor
// Notes:   registers reached by command code writes and reads
//
// What this block does
// [R1] five two-bit action fields, nc down to ov
// [R2] bit 15 enables peak save; 14:10 reserved
// [R3] code 00: flag, alert, keep running
// [R4] code 01: flag, alert, shut down, save peaks
// [R5] code 10: flag, alert, shut down, retry periodically
// [R6] code 11: flag and continue, save peaks
// [R7] shutdown drops supply enable at once
// [R8] reference dac ramps down, never steps
// [R9] latched shutdown stays off until commanded on
// [R10] action config resets to zero
// [R11] restart delay is interval times 100 us
// [R12] one interval serves all retry faults
// [R13] zero interval restarts at next period
// [R14] restart interval resets to zero
// [R15] peak save ignores the store lock
// [R16] any fault sets flag and alert
// [R17] expired delay re-enables; persistent fault repeats
`timescale 1ns/1ps
`include "frrc_regs.vh"

module frrc_ctrl #(
  parameter RETRY_UNIT_CYC = `FRRC_RETRY_UNIT_CYC
) (
  input  wire        CLK,
  input  wire        RST_B,
  input  wire [7:0]  CMD_CODE,
  input  wire [15:0] CMD_WDATA,
  input  wire        CMD_WR,
  input  wire        CMD_RD,
  input  wire        CLEAR_FAULTS,
  input  wire        ON_CMD,
  input  wire        OFF_CMD,
  input  wire [4:0]  FAULT_DET,
  input  wire [11:0] DAC_TARGET,
  output reg  [15:0] RD_DATA,
  output reg         SUPPLY_ENABLE_OUT,
  output reg         FAULT_ALERT_N,
  output reg         STORE_PEAK_REQ,
  output wire [11:0] REFERENCE_DAC_OUTPUT
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam ST_OFF   = 2'h0;
  localparam ST_ON    = 2'h1;
  localparam ST_RETRY = 2'h2;

  reg  [15:0] action_q;
  reg  [15:0] interval_q;
  reg  [4:0]  flags_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [16:0] unit_cnt_q;
  reg  [15:0] wait_q;
  reg  [4:0]  step_cnt_q;
  wire        unit_tick;
  wire        dac_step;
  wire [4:0]  act_latch;
  wire [4:0]  act_retry;
  wire [4:0]  act_store;
  wire        any_fault;
  wire        shut_latch;
  wire        shut_retry;
  wire        store_hit;
  wire        retry_done;

  // ---------------------------------------------------------------
  // per-fault action decode
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `FRRC_NUM_FAULTS; g = g + 1)
    begin : g_act
      wire [1:0] code = action_q[2*g+1:2*g]; // R1
      assign act_latch[g] = FAULT_DET[g] &&
                            code == `FRRC_ACT_LATCH; // R4
      assign act_retry[g] = FAULT_DET[g] &&
                            code == `FRRC_ACT_RETRY; // R5
      // 00 takes no part in shutdown or store
      assign act_store[g] = FAULT_DET[g] &&
                            code != `FRRC_ACT_FLAG; // R3 R6
    end
  endgenerate

  assign any_fault  = |FAULT_DET;
  assign shut_latch = |act_latch;
  assign shut_retry = |act_retry;
  // no store-lock input exists: a fault save bypasses it by design
  assign store_hit  = action_q[`FRRC_STORE_PEAK_BIT] && |act_store; // R15

  // ---------------------------------------------------------------
  // command registers
  // ---------------------------------------------------------------
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      action_q   <= `FRRC_ACTION_RST; // R10
      interval_q <= `FRRC_INTERVAL_RST; // R14
    end
    else if (CMD_WR)
    begin
      if (CMD_CODE == `FRRC_CMD_ACTION)
        action_q <= CMD_WDATA & `FRRC_ACTION_MASK; // R2
      if (CMD_CODE == `FRRC_CMD_INTERVAL)
        interval_q <= CMD_WDATA;
    end
  end

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      RD_DATA <= 16'h0000;
    else if (CMD_RD)
    begin
      case (CMD_CODE)
        `FRRC_CMD_FLAGS:    RD_DATA <= {11'h000, flags_q};
        `FRRC_CMD_ACTION:   RD_DATA <= action_q;
        `FRRC_CMD_INTERVAL: RD_DATA <= interval_q;
        default:            RD_DATA <= 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // fault flags and alert
  // ---------------------------------------------------------------
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      flags_q        <= 5'h00;
      FAULT_ALERT_N  <= 1'b1;
      STORE_PEAK_REQ <= 1'b0;
    end
    else
    begin
      // set beats a clear in the same cycle
      flags_q <= (CLEAR_FAULTS ? 5'h00 : flags_q) | FAULT_DET; // R16
      FAULT_ALERT_N  <= !(any_fault ||
                          (!CLEAR_FAULTS && flags_q != 5'h00)); // R16
      STORE_PEAK_REQ <= store_hit; // R4 R5 R6
    end
  end

  // ---------------------------------------------------------------
  // 100 us time base and dac step
  // ---------------------------------------------------------------
  assign unit_tick = unit_cnt_q == RETRY_UNIT_CYC - 1;
  assign dac_step  = step_cnt_q == `FRRC_DAC_STEP_CYC - 1;

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      unit_cnt_q <= 17'h0_0000;
      step_cnt_q <= 5'h00;
    end
    else
    begin
      unit_cnt_q <= unit_tick ? 17'h0_0000 : unit_cnt_q + 17'h0_0001;
      step_cnt_q <= dac_step ? 5'h00 : step_cnt_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // supply state machine
  // ---------------------------------------------------------------
  // zero interval still waits for the next time-base period
  assign retry_done = unit_tick && wait_q == 16'h0000; // R11 R13

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_OFF:
        // a shutdown fault on the turn-on edge keeps the supply down
        if (ON_CMD && !shut_latch)
          state_d = shut_retry ? ST_RETRY : ST_ON; // R7 R9
      ST_ON:
        if (OFF_CMD || shut_latch)
          state_d = ST_OFF; // R4 R7
        else if (shut_retry)
          state_d = ST_RETRY; // R5 R7
      ST_RETRY:
        if (OFF_CMD || shut_latch)
          state_d = ST_OFF;
        else if (retry_done && !shut_retry)
          state_d = ST_ON; // R7 R17
      default:
        state_d = ST_OFF;
    endcase
  end

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_q           <= ST_OFF;
      SUPPLY_ENABLE_OUT <= 1'b0;
      wait_q            <= 16'h0000;
    end
    else
    begin
      state_q           <= state_d;
      SUPPLY_ENABLE_OUT <= state_d == ST_ON; // R7 R17
      // a repeated retry fault starts the wait over
      if (state_q != ST_RETRY || shut_retry)
        wait_q <= interval_q; // R12 R17
      else if (unit_tick && wait_q != 16'h0000)
        wait_q <= wait_q - 16'h0001; // R11
    end
  end

  // ---------------------------------------------------------------
  // reference dac
  // ---------------------------------------------------------------
  frrc_ramp u_ramp (
    .clk    (CLK),
    .rst_b  (RST_B),
    .run    (SUPPLY_ENABLE_OUT),
    .target (DAC_TARGET),
    .step   (dac_step),
    .dac_q  (REFERENCE_DAC_OUTPUT)
  );

endmodule // frrc_ctrl

// *** verification/frrc_ctrl_asserts.sv ***
// Purpose: port checks of the fault response controller
// Assumes: action config shadowed from command writes
// Notes:   bound into every frrc_ctrl
`timescale 1ns/1ps
`include "frrc_regs.vh"
module frrc_ctrl_chk (
  input wire        CLK,
  input wire        RST_B,
  input wire [7:0]  CMD_CODE,
  input wire [15:0] CMD_WDATA,
  input wire        CMD_WR,
  input wire        CMD_RD,
  input wire        CLEAR_FAULTS,
  input wire        OFF_CMD,
  input wire [4:0]  FAULT_DET,
  input wire [15:0] RD_DATA,
  input wire        SUPPLY_ENABLE_OUT,
  input wire        FAULT_ALERT_N,
  input wire        STORE_PEAK_REQ,
  input wire [11:0] REFERENCE_DAC_OUTPUT
);
  reg  [15:0] act_q;
  wire [4:0]  lo = {act_q[8], act_q[6], act_q[4], act_q[2], act_q[0]};
  wire [4:0]  hi = {act_q[9], act_q[7], act_q[5], act_q[3], act_q[1]};
  wire        shut = |(FAULT_DET & (lo ^ hi));
  wire        st = act_q[15] & (|(FAULT_DET & (lo | hi)));
  always @(posedge CLK or negedge RST_B)
    if (!RST_B)
      act_q <= 16'h0000;
    else if (CMD_WR && CMD_CODE == `FRRC_CMD_ACTION)
      act_q <= CMD_WDATA & `FRRC_ACTION_MASK;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  chk_flag_alert: assert property (|FAULT_DET |=> !FAULT_ALERT_N)
    else $error("alert missing");
  chk_shut_now: assert property (shut |=> !SUPPLY_ENABLE_OUT)
    else $error("enable not dropped");
  chk_keep_run: assert property (SUPPLY_ENABLE_OUT && !shut && !OFF_CMD
    |=> SUPPLY_ENABLE_OUT)
    else $error("enable dropped");
  chk_store_cause: assert property (1 |=> STORE_PEAK_REQ == $past(st))
    else $error("store pulse wrong");
  chk_dac_slew: assert property ({1'b0, REFERENCE_DAC_OUTPUT} + 13'h0001
    >= {1'b0, $past(REFERENCE_DAC_OUTPUT)})
    else $error("dac stepped down");
  chk_alert_hold: assert property (!FAULT_ALERT_N && !CLEAR_FAULTS
    |=> !FAULT_ALERT_N)
    else $error("alert dropped early");
  chk_alert_clear: assert property (CLEAR_FAULTS && !(|FAULT_DET) ##1
    !(|FAULT_DET) |=> FAULT_ALERT_N)
    else $error("alert stuck");
  chk_rd_action: assert property (CMD_RD && CMD_CODE == `FRRC_CMD_ACTION
    |=> RD_DATA == $past(act_q))
    else $error("action readback");
  cover property (shut ##1 !SUPPLY_ENABLE_OUT);
  cover property (STORE_PEAK_REQ);
  cover property ($rose(SUPPLY_ENABLE_OUT));
endmodule // frrc_ctrl_chk
bind frrc_ctrl frrc_ctrl_chk u_frrc_ctrl_chk (.*);

// *** verification/frrc_pol_model.sv ***
// Purpose: load supply model, counts every start, first turn-on included
// Assumes: output follows enable at once
// Notes:   reference code only observed
`timescale 1ns/1ps
module frrc_pol_model (
  input wire        clk,
  input wire        enable,
  input wire [11:0] ref_code,
  output reg [7:0]  starts = 8'h00
);
  reg en_q = 1'b0;
  always @(posedge clk)
  begin
    en_q <= enable;
    if (enable && !en_q)
      starts <= starts + 8'h01;
  end
endmodule // frrc_pol_model

// *** verification/frrc_ctrl_tb.sv ***
// Purpose: directed tests of the fault response controller
// Assumes: retry unit shortened to 10 cycles
// Notes:   ctl packs clear, on, off and fault pulses
`timescale 1ns/1ps
`include "frrc_regs.vh"
module frrc_ctrl_tb;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg  [7:0]  code = 8'h00;
  reg  [15:0] wdata = 16'h0000;
  reg  [7:0]  ctl = 8'h00;
  wire [15:0] rdata;
  wire        en;
  wire        alert_n;
  wire        store;
  wire [11:0] dac;
  wire [7:0]  starts;
  integer     n_errors = 0;
  integer     total_checks = 0;
  integer     n;
  integer     i;
  always #4 clk = ~clk;
  frrc_ctrl #(.RETRY_UNIT_CYC(10)) u_frrc_ctrl (.CLK(clk), .RST_B(rst_b),
    .CMD_CODE(code), .CMD_WDATA(wdata), .CMD_WR(wr), .CMD_RD(rd),
    .CLEAR_FAULTS(ctl[7]), .ON_CMD(ctl[6]), .OFF_CMD(ctl[5]),
    .FAULT_DET(ctl[4:0]), .DAC_TARGET(12'h010), .RD_DATA(rdata),
    .SUPPLY_ENABLE_OUT(en), .FAULT_ALERT_N(alert_n),
    .STORE_PEAK_REQ(store), .REFERENCE_DAC_OUTPUT(dac));
  frrc_pol_model u_frrc_pol_model (.clk(clk), .enable(en),
    .ref_code(dac), .starts(starts));
  task chk(input [15:0] got, input [15:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task acc(input w, input [7:0] c, input [15:0] d);
  begin
    @(posedge clk);
    code <= c;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    if (!w)
      chk(rdata, d);
  end
  endtask
  task pulse(input [7:0] v);
  begin
    @(posedge clk);
    ctl <= v;
    @(posedge clk);
    ctl <= 8'h00;
    @(negedge clk);
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    acc(0, `FRRC_CMD_ACTION, 16'h0000);
    acc(0, `FRRC_CMD_INTERVAL, 16'h0000);
    acc(1, `FRRC_CMD_ACTION, 16'hFFFF);
    acc(0, `FRRC_CMD_ACTION, 16'h83FF);
    acc(1, `FRRC_CMD_ACTION, 16'h0000);
    $display("test regs done");
    pulse(8'h40);
    repeat (300) @(negedge clk);
    pulse(8'h01);
    chk({alert_n, en, store}, 16'h0002);
    acc(0, `FRRC_CMD_FLAGS, 16'h0001);
    pulse(8'h80);
    @(negedge clk);
    chk(alert_n, 16'h0001);
    acc(0, `FRRC_CMD_FLAGS, 16'h0000);
    acc(1, `FRRC_CMD_ACTION, 16'h8001);
    pulse(8'h01);
    chk({alert_n, en, store}, 16'h0001);
    chk(dac != 12'h000, 16'h0001);
    repeat (200) @(negedge clk);
    chk(en, 16'h0000);
    pulse(8'hC0);
    chk(en, 16'h0001);
    acc(1, `FRRC_CMD_ACTION, 16'h800C);
    pulse(8'h02);
    chk({alert_n, en, store}, 16'h0003);
    pulse(8'h20);
    chk(en, 16'h0000);
    pulse(8'h40);
    chk(en, 16'h0001);
    $display("test actions done");
    acc(1, `FRRC_CMD_ACTION, 16'h02A0);
    for (i = 0; i < 4; i = i + 1)
    begin
      acc(1, `FRRC_CMD_INTERVAL, (i < 2) ? 16'h0003 : 16'h0000);
      pulse((i < 2) ? 8'h04 : 8'h04 << (i - 1));
      chk(en, 16'h0000);
      n = 0;
      while (en !== 1'b1 && n < 200)
      begin
        @(negedge clk);
        n = n + 1;
      end
      chk(n >= 30 * (i < 2) && n <= 30 * (i < 2) + 12, 1);
      // model counts one edge after the enable rises
      @(negedge clk);
      chk(starts, i + 4);
    end
    acc(0, `FRRC_CMD_FLAGS, 16'h001E);
    $display("test retry done");
    acc(1, `FRRC_CMD_INTERVAL, 16'h1234);
    acc(0, `FRRC_CMD_INTERVAL, 16'h1234);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    acc(0, `FRRC_CMD_ACTION, 16'h0000);
    acc(0, `FRRC_CMD_INTERVAL, 16'h0000);
    chk({alert_n, en}, 16'h0002);
    $display("test reset done");
    give_verdict;
  end
  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    give_verdict;
  end
endmodule // frrc_ctrl_tb
